// ==== verilog/spmp_defs.vh ====
`ifndef SPMP_DEFS_VH
`define SPMP_DEFS_VH
// Control field positions inside the 8-bit control word
`define SPMP_CTL_IRQ_EN    7
`define SPMP_CTL_ENABLE    6
`define SPMP_CTL_LSB_FIRST 5
`define SPMP_CTL_MASTER    4
`define SPMP_CTL_CPOL      3
`define SPMP_CTL_CPHA      2
`define SPMP_CTL_RATE_HI   1
`define SPMP_CTL_RATE_LO   0
// Reset values
`define SPMP_CTL_RESET     8'h00
`define SPMP_BYTE_RESET    8'h00
// Transfer shape and data buffer
`define SPMP_BITS          8
`define SPMP_FIFO_DEPTH    8
`endif

// ==== verilog/spmp_fifo.v ====
module spmp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             reset,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data_q
);
  // ==========================================================
  // Storage and pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  reg             ov_q;
  wire            push;
  wire            pop;

  // Read data is registered: a popped word appears one cycle after pop
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = ov_q;
  assign push      = in_valid & in_ready;
  assign pop       = (cnt_q != {(AW+1){1'b0}}) & (~ov_q | out_ready);

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_q       <= {AW{1'b0}};
      rd_q       <= {AW{1'b0}};
      cnt_q      <= {(AW+1){1'b0}};
      ov_q       <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q       <= rd_q + 1'b1;
        out_data_q <= mem[rd_q];
        ov_q       <= 1'b1;
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // spmp_fifo

// ==== verilog/spmp_port.v ====
`include "spmp_defs.vh"
// Notes on behaviour
// RULE1: Master data write starts eight-bit shift
// RULE2: Clock stops, done flag set per byte
// RULE3: Done flag with enable requests interrupt
// RULE4: Master never drives select by itself
// RULE5: Deselected slave idle, MISO released
// RULE6: Deselected slave accepts data write
// RULE7: MOSI master to slave, MISO back
// RULE8: Master frames packets with select
// RULE9: Next byte continues, select high ends
// RULE10: Last received byte stays readable
// RULE11: Software waits for shift completion
// RULE12: Unread byte overwritten by next byte; here a byte arriving with the buffer full is dropped instead
// RULE13: Slave may load before reading
// RULE14: External clock at most core/4
// RULE15: Pin directions overridden by mode
// RULE16: Power gate high disables port
// RULE17: Seven rates including core/2
// RULE18: Bit order selectable
// RULE19: Write during transfer flags collision
// RULE20: Done event wakes idle processor
// RULE21: Select high resets slave shifter
// RULE22: Select low as master forces slave
// RULE23: Four clock modes, opposite edges
// RULE24: Interrupt level while flag and enable
// RULE25: Reset: disabled, slave, flag clear
module spmp_port (
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset,
  // Control
  input  wire       serial_power_gate,
  input  wire [7:0] ctl_wdata,
  input  wire       ctl_we,
  input  wire       double_speed,
  output reg  [7:0] serial_control_reg_q,
  // Data writes and reads
  input  wire [7:0] tx_wdata,
  input  wire       tx_we,
  output reg  [7:0] rx_data_q,
  output reg        rx_valid_q,
  input  wire       rx_read,
  output reg        rx_lost_q,
  // Status
  output reg        transfer_done_flag_q,
  input  wire       done_clear,
  output reg        write_collision_q,
  output reg        busy_q,
  output reg        irq_q,
  output reg        wake_q,
  // Software pin directions for user-defined pins
  input  wire       mosi_dir,
  input  wire       sck_dir,
  input  wire       ss_dir,
  input  wire       miso_dir,
  // Pins
  input  wire       sck_i,
  output reg        sck_o_q,
  output reg        sck_oe_q,
  input  wire       mosi_i,
  output reg        mosi_o_q,
  output reg        mosi_oe_q,
  input  wire       miso_i,
  output reg        miso_o_q,
  output reg        miso_oe_q,
  input  wire       ss_n_i,
  output reg        ss_oe_q
);
  // ==========================================================
  // Helpers
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  function [6:0] half_div;
    input       dbl;
    input [1:0] rate;
    begin
      case ({dbl, rate})
        3'b000:  half_div = 7'h02;
        3'b001:  half_div = 7'h08;
        3'b010:  half_div = 7'h20;
        3'b011:  half_div = 7'h40;
        3'b100:  half_div = 7'h01;
        3'b101:  half_div = 7'h04;
        3'b110:  half_div = 7'h10;
        default: half_div = 7'h20;
      endcase
    end
  endfunction

  function out_bit;
    input [7:0] sr;
    input       lsb;
    begin
      out_bit = lsb ? sr[0] : sr[7];
    end
  endfunction

  function [7:0] shift_in;
    input [7:0] sr;
    input       lsb;
    input       b;
    begin
      shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
    end
  endfunction

  // ==========================================================
  // Control decode
  wire [7:0] ctl     = serial_control_reg_q;
  wire       en      = ctl[`SPMP_CTL_ENABLE] & ~serial_power_gate; // see RULE16
  wire       master  = ctl[`SPMP_CTL_MASTER];
  wire       cpol    = ctl[`SPMP_CTL_CPOL];
  wire       cpha    = ctl[`SPMP_CTL_CPHA];
  wire       lsb     = ctl[`SPMP_CTL_LSB_FIRST];                  // see RULE18
  wire [6:0] hdiv    = half_div(double_speed,
                                ctl[`SPMP_CTL_RATE_HI:`SPMP_CTL_RATE_LO]); // see RULE17

  reg        state_q;
  reg  [7:0] sr_q;
  reg  [3:0] edges_q;
  reg  [6:0] div_q;
  reg        sck_prev_q;
  reg        ss_prev_q;
  reg        done_ev;
  reg  [7:0] done_byte;

  // Mode fault: another master selects us
  wire mode_fault = en & master & ~ss_dir & ~ss_n_i;   // see RULE22
  wire slave_sel  = en & ~master & ~ss_n_i;

  // Slave edge detection; inputs taken as synchronous, so no extra stages
  wire sck_rise   = sck_i & ~sck_prev_q;
  wire sck_fall   = ~sck_i & sck_prev_q;
  wire lead_edge  = cpol ? sck_fall : sck_rise;
  wire trail_edge = cpol ? sck_rise : sck_fall;
  wire s_sample   = cpha ? trail_edge : lead_edge;     // see RULE23
  wire s_setup    = cpha ? lead_edge : trail_edge;
  wire ss_fall    = ss_prev_q & ~ss_n_i;

  // Received bytes pass through the buffer; the full flag stalls nothing on
  // the line, so a byte arriving with the buffer full is dropped and flagged as lost in rx_lost_q
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;

  spmp_fifo #(
    .WIDTH (`SPMP_BITS),
    .DEPTH (`SPMP_FIFO_DEPTH),
    .AW    (3)
  ) u_rx_fifo (
    .core_clk   (core_clk),
    .reset      (reset),
    .in_valid   (done_ev),
    .in_ready   (fifo_in_ready),
    .in_data    (done_byte),
    .out_valid  (fifo_out_valid),
    .out_ready  (~rx_valid_q | rx_read),
    .out_data_q (fifo_out_data)
  );

  // ==========================================================
  // Shift engine
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      serial_control_reg_q <= `SPMP_CTL_RESET;                     // see RULE25
      state_q              <= ST_IDLE;
      sr_q                 <= `SPMP_BYTE_RESET;
      edges_q              <= 4'h0;
      div_q                <= 7'h00;
      sck_prev_q           <= 1'b0;
      ss_prev_q            <= 1'b1;
      sck_o_q              <= 1'b0;
      transfer_done_flag_q <= 1'b0;
      write_collision_q    <= 1'b0;
      busy_q               <= 1'b0;
      done_ev              <= 1'b0;
      done_byte            <= `SPMP_BYTE_RESET;
      mosi_o_q             <= 1'b0;
      miso_o_q             <= 1'b0;
    end else begin
      sck_prev_q <= sck_i;
      ss_prev_q  <= ss_n_i;
      done_ev    <= 1'b0;
      if (ctl_we) begin
        serial_control_reg_q <= ctl_wdata;
      end
      if (done_clear) begin
        transfer_done_flag_q <= 1'b0;
        write_collision_q    <= 1'b0;
      end
      // Writes while busy are dropped; hold data until next transfer otherwise
      if (tx_we & busy_q) begin
        write_collision_q <= 1'b1;                                  // see RULE19
      end else if (tx_we) begin
        sr_q <= tx_wdata;                                           // see RULE6
        // Phase 0 slave must show the first bit before any clock edge
        if (~master & ~cpha) begin
          miso_o_q <= out_bit(tx_wdata, lsb);                       // see RULE13
        end
        if (en & master & ~mode_fault) begin
          state_q <= ST_RUN;                                        // see RULE1
          busy_q  <= 1'b1;
          edges_q <= 4'h0;
          div_q   <= hdiv;
          sck_o_q <= cpol;
          if (~cpha) begin
            mosi_o_q <= out_bit(tx_wdata, lsb);
          end
        end
      end
      if (~en) begin
        state_q <= ST_IDLE;
        busy_q  <= 1'b0;
        sck_o_q <= cpol;
      end else if (mode_fault) begin
        serial_control_reg_q[`SPMP_CTL_MASTER] <= 1'b0;             // see RULE22
        transfer_done_flag_q <= 1'b1;
        state_q              <= ST_IDLE;
        busy_q               <= 1'b0;
        sck_o_q              <= cpol;
      end else if (master & state_q == ST_RUN) begin
        if (div_q > 7'h01) begin
          div_q <= div_q - 7'h01;
        end else begin
          div_q   <= hdiv;
          sck_o_q <= ~sck_o_q;
          edges_q <= edges_q + 4'h1;
          // Even edges (0,2..) are leading, odd are trailing
          if (edges_q[0] == cpha) begin
            sr_q <= shift_in(sr_q, lsb, miso_i);                    // see RULE7
          end else if (edges_q != 4'hF) begin
            mosi_o_q <= out_bit(sr_q, lsb);
          end
          if (edges_q == 4'hF) begin
            state_q              <= ST_IDLE;                        // see RULE2
            busy_q               <= 1'b0;
            transfer_done_flag_q <= 1'b1;
            done_ev              <= 1'b1;
            done_byte            <= cpha ? shift_in(sr_q, lsb, miso_i) : sr_q;
          end
        end
      end else if (master) begin
        // Idle master follows the polarity bit, so a mode change between
        // bytes shows up at once as a clock edge at the selected slave
        sck_o_q <= cpol;                                            // see RULE23
      end else begin
        if (ss_n_i | ~en) begin
          edges_q <= 4'h0;                                          // see RULE21
          busy_q  <= 1'b0;
        end else begin
          if (ss_fall & ~cpha) begin
            miso_o_q <= out_bit(sr_q, lsb);
          end
          if (s_sample) begin
            sr_q    <= shift_in(sr_q, lsb, mosi_i);                 // see RULE7
            busy_q  <= 1'b1;
            edges_q <= edges_q + 4'h1;
            if (edges_q == 4'h7) begin
              transfer_done_flag_q <= 1'b1;                         // see RULE2
              done_ev              <= 1'b1;
              done_byte            <= shift_in(sr_q, lsb, mosi_i);
              edges_q              <= 4'h0;
              busy_q               <= 1'b0;
            end
          end else if (s_setup & (cpha | edges_q != 4'h0)) begin
            miso_o_q <= out_bit(sr_q, lsb);
          end
        end
      end
    end
  end

  // ==========================================================
  // Receive buffer, status, pins
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_data_q  <= `SPMP_BYTE_RESET;
      rx_valid_q <= 1'b0;
      rx_lost_q  <= 1'b0;
      irq_q      <= 1'b0;
      wake_q     <= 1'b0;
      sck_oe_q   <= 1'b0;
      mosi_oe_q  <= 1'b0;
      miso_oe_q  <= 1'b0;
      ss_oe_q    <= 1'b0;
    end else begin
      if (fifo_out_valid & (~rx_valid_q | rx_read)) begin
        rx_data_q  <= fifo_out_data;                                // see RULE10
        rx_valid_q <= 1'b1;
      end else if (rx_read) begin
        rx_valid_q <= 1'b0;
      end
      if (done_ev & ~fifo_in_ready) begin
        rx_lost_q <= 1'b1;                                          // see RULE12
      end else if (done_clear) begin
        rx_lost_q <= 1'b0;
      end
      irq_q     <= transfer_done_flag_q & ctl[`SPMP_CTL_IRQ_EN];    // see RULE3 RULE24
      wake_q    <= done_ev;                                         // see RULE20
      // Select is never driven by the engine itself
      ss_oe_q   <= en & master & ss_dir;                            // see RULE4
      sck_oe_q  <= en & master & sck_dir;                           // see RULE15
      mosi_oe_q <= en & master & mosi_dir;
      miso_oe_q <= slave_sel & miso_dir;                            // see RULE5
    end
  end
endmodule // spmp_port

// ==== test/spmp_port_checker.sv ====
module spmp_port_checker (
  // Clock and reset
  input wire       core_clk,
  input wire       reset,
  // Control and status
  input wire       serial_power_gate,
  input wire       ctl_we,
  input wire [7:0] serial_control_reg_q,
  input wire       tx_we,
  input wire       busy_q,
  input wire       write_collision_q,
  input wire       transfer_done_flag_q,
  input wire       irq_q,
  input wire       wake_q,
  // Pins
  input wire       ss_dir,
  input wire       ss_n_i,
  input wire       mosi_oe_q,
  input wire       sck_oe_q,
  input wire       miso_oe_q,
  input wire       ss_oe_q
);
  timeunit 1ns;
  timeprecision 1ps;
  wire run_m = serial_control_reg_q[6] & serial_control_reg_q[4];
  wire run_s = serial_control_reg_q[6] & !serial_control_reg_q[4];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Busy length counter; saturates so it never wraps back under the limit
  logic [10:0] busy_len_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset) busy_len_q <= 11'h000;
    else if (!busy_q) busy_len_q <= 11'h000;
    else if (busy_len_q != 11'h7FF) busy_len_q <= busy_len_q + 11'h001;
  end
  // ==========================================
  // Transfer
  a_start_shift: assert property (tx_we && !busy_q && run_m && !serial_power_gate
    && (ss_dir || ss_n_i) |=> busy_q) else $error("transfer did not start");
  a_shift_ends: assert property (busy_q |-> busy_len_q < 11'h44C)
    else $error("transfer never ended");
  // A slave cut short by its select or a disabled port ends without the flag
  a_flag_at_end: assert property ($fell(busy_q) && !serial_power_gate
    && serial_control_reg_q[6] && (serial_control_reg_q[4] || !ss_n_i)
    |-> transfer_done_flag_q) else $error("done flag missing at end");
  a_wake_pulse: assert property ($fell(busy_q) && $rose(transfer_done_flag_q)
    && !$past(run_m && !ss_dir && !ss_n_i) |-> ##[0:2] wake_q)
    else $error("no wake pulse");
  a_irq_raise: assert property (transfer_done_flag_q && serial_control_reg_q[7] |=> irq_q)
    else $error("irq not raised");
  a_irq_drop: assert property (!transfer_done_flag_q |=> !irq_q)
    else $error("irq without flag");
  a_write_collide: assert property (tx_we && busy_q && run_m |=> write_collision_q)
    else $error("collision not flagged");
  // ==========================================
  // Pins and modes
  a_select_own: assert property ((!ss_dir)[*3] |-> !ss_oe_q)
    else $error("select driven by port");
  a_slave_quiet: assert property ((run_s && ss_n_i)[*3] |-> !miso_oe_q)
    else $error("deselected slave drives miso");
  a_master_dirs: assert property (run_m[*3] |-> !miso_oe_q)
    else $error("master drives miso");
  a_slave_dirs: assert property (run_s[*3] |-> !(mosi_oe_q | sck_oe_q | ss_oe_q))
    else $error("slave drives an input pin");
  a_gate_idle: assert property (serial_power_gate[*3] |-> !busy_q)
    else $error("gated port busy");
  a_fault_slave: assert property (run_m && !ss_dir && !ss_n_i && !ctl_we
    && !serial_power_gate
    |-> ##[1:4] !serial_control_reg_q[4]) else $error("mode fault ignored");
endmodule // spmp_port_checker

bind spmp_port spmp_port_checker u_chk (.core_clk(core_clk), .reset(reset),
  .serial_power_gate(serial_power_gate), .ctl_we(ctl_we),
  .serial_control_reg_q(serial_control_reg_q), .tx_we(tx_we), .busy_q(busy_q),
  .write_collision_q(write_collision_q), .transfer_done_flag_q(transfer_done_flag_q),
  .irq_q(irq_q), .wake_q(wake_q), .ss_dir(ss_dir), .ss_n_i(ss_n_i), .mosi_oe_q(mosi_oe_q),
  .sck_oe_q(sck_oe_q), .miso_oe_q(miso_oe_q), .ss_oe_q(ss_oe_q));

// ==== test/spmp_slave_model.sv ====
module spmp_slave_model (
  // Serial pins
  input  wire        sck,
  input  wire        sel_n,
  input  wire        mosi,
  output wire        miso,
  // Mode and data
  input  wire  [7:0] cfg,
  input  wire  [7:0] load,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr_q;
  logic       first;
  wire        lead = sck ^ cfg[3];
  wire        bit_out = cfg[5] ? sr_q[0] : sr_q[7];
  // Released line shows the inverse so a stale bit never passes
  assign miso = sel_n ? ~bit_out : bit_out;
  always @(negedge sel_n) begin
    sr_q = load;
    first = 1'b1;
  end
  // Sample and launch on opposite edges per polarity and phase
  always @(lead) begin
    if (!sel_n) begin
      if (lead ^ cfg[2]) got = cfg[5] ? {mosi, got[7:1]} : {got[6:0], mosi};
      else if (cfg[2] && first) first = 1'b0;
      else sr_q = cfg[5] ? sr_q >> 1 : sr_q << 1;
    end
  end
endmodule // spmp_slave_model

// ==== test/spmp_port_test.sv ====
module spmp_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 0, reset = 1, serial_power_gate = 0, ctl_we = 0, double_speed = 0;
  logic       tx_we = 0, rx_read = 0, done_clear = 0, mosi_dir = 1, sck_dir = 1, ss_dir = 0;
  logic       miso_dir = 1, ss_n_i = 1, tb_sck = 0, tb_mosi = 0, msel_n = 1;
  logic [7:0] ctl_wdata = 0, tx_wdata = 0, load = 0, cap = 0, serial_control_reg_q, rx_data_q, got;
  logic       rx_valid_q, rx_lost_q, transfer_done_flag_q, write_collision_q, busy_q, irq_q;
  logic       wake_q, sck_o_q, sck_oe_q, mosi_o_q, mosi_oe_q, miso_o_q, miso_oe_q, ss_oe_q, m_miso;
  wire        sck_i = sck_oe_q ? sck_o_q : tb_sck;
  wire        mosi_i = mosi_oe_q ? mosi_o_q : tb_mosi;
  wire        miso_i = miso_oe_q ? miso_o_q : m_miso;
  int         failures = 0, check_count = 0;
  spmp_port dut (.core_clk(core_clk), .reset(reset), .serial_power_gate(serial_power_gate),
    .ctl_wdata(ctl_wdata), .ctl_we(ctl_we), .double_speed(double_speed),
    .serial_control_reg_q(serial_control_reg_q), .tx_wdata(tx_wdata), .tx_we(tx_we),
    .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .rx_read(rx_read), .rx_lost_q(rx_lost_q),
    .transfer_done_flag_q(transfer_done_flag_q), .done_clear(done_clear),
    .write_collision_q(write_collision_q), .busy_q(busy_q), .irq_q(irq_q), .wake_q(wake_q),
    .mosi_dir(mosi_dir), .sck_dir(sck_dir), .ss_dir(ss_dir), .miso_dir(miso_dir),
    .sck_i(sck_i), .sck_o_q(sck_o_q), .sck_oe_q(sck_oe_q), .mosi_i(mosi_i),
    .mosi_o_q(mosi_o_q), .mosi_oe_q(mosi_oe_q), .miso_i(miso_i), .miso_o_q(miso_o_q),
    .miso_oe_q(miso_oe_q), .ss_n_i(ss_n_i), .ss_oe_q(ss_oe_q));
  spmp_slave_model peer (.sck(sck_i), .sel_n(msel_n), .mosi(mosi_i), .miso(m_miso),
    .cfg(ctl_wdata), .load(load), .got(got));
  always #4 core_clk = ~core_clk;
  // ==========================================
  // Tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 3000 && transfer_done_flag_q !== 1'b1; i++) tick(1);
    if (i == 3000) begin
      failures++;
      end_of_test;
    end
    tick(5);
  endtask
  task automatic put_ctl(input logic [7:0] c);
    ctl_wdata = c;
    ctl_we = 1;
    tick(1);
    ctl_we = 0;
    tick(1);
  endtask
  task automatic put_tx(input logic [7:0] d);
    tx_wdata = d;
    tx_we = 1;
    tick(1);
    tx_we = 0;
  endtask
  task automatic clear;
    done_clear = 1;
    rx_read = 1;
    tick(1);
    done_clear = 0;
    rx_read = 0;
    tick(1);
  endtask
  // Slave frames at a quarter of the core rate at most
  task automatic sbyte(input int n, input logic [7:0] d);
    for (int b = 0; b < n; b++) begin
      tb_mosi = d[7-b];
      tick(4);
      cap = {cap[6:0], miso_i};
      tb_sck = 1;
      tick(4);
      tb_sck = 0;
    end
  endtask
  task automatic mxfer(input logic [2:0] i);
    logic [7:0] d;
    d = 8'hA5 ^ {5'h00, i};
    load = 8'h3C + {5'h00, i};
    double_speed = i[0];
    put_ctl({i[1], 1'b1, i[2], 1'b1, i[1:0], i[2:1]});
    msel_n = 0;
    put_tx(d);
    tick(1);
    put_tx(8'hFF);
    wait_done;
    chk("peer_rx", d, got);
    chk("rx_data", load, rx_data_q);
    chk("rx_valid", 8'h01, {7'h00, rx_valid_q});
    chk("irq", {7'h00, i[1]}, {7'h00, irq_q});
    chk("collision", 8'h01, {7'h00, write_collision_q});
    msel_n = 1;
    clear;
  endtask
  // ==========================================
  // Sequence
  initial begin
    tick(10);
    reset = 0;
    tick(1);
    chk("ctl", 8'h00, serial_control_reg_q);
    chk("status", 8'h00, {busy_q, transfer_done_flag_q, sck_oe_q, mosi_oe_q, miso_oe_q,
      ss_oe_q, irq_q, 1'b0});
    for (int i = 0; i < 8; i++) mxfer(i[2:0]);
    serial_power_gate = 1;
    put_ctl(8'h50);
    put_tx(8'h81);
    tick(4);
    chk("gated", 8'h00, {6'h00, busy_q, sck_oe_q});
    serial_power_gate = 0;
    put_ctl(8'h50);
    ss_n_i = 0;
    tick(4);
    chk("fault", 8'h41, {serial_control_reg_q[7:4], 3'h0, transfer_done_flag_q});
    ss_n_i = 1;
    clear;
    put_tx(8'h96);
    sbyte(8, 8'hFF);
    chk("idle", 8'h00, {6'h00, transfer_done_flag_q, miso_oe_q});
    ss_n_i = 0;
    sbyte(8, 8'h5B);
    wait_done;
    chk("slave_tx", 8'h96, cap);
    put_tx(8'h11);
    chk("slave_rx", 8'h5B, rx_data_q);
    clear;
    sbyte(3, 8'hE0);
    ss_n_i = 1;
    tick(4);
    ss_n_i = 0;
    sbyte(8, 8'hC3);
    wait_done;
    chk("resync", 8'hC3, rx_data_q);
    // Held byte, output stage and eight buffered words fill up; the tenth is lost
    for (int k = 0; k < 10; k++) sbyte(8, 8'h20 + k[7:0]);
    tick(8);
    chk("lost", 8'h01, {7'h00, rx_lost_q});
    end_of_test;
  end
endmodule // spmp_port_test
